// ==== sar_adc_pkg.sv ====
// Purpose: Shared constants and carrier types for the SAR converter control block.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes:   Offsets 0x0e/0x0f are register indices; byte address is four times the index.

package sar_adc_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] IDX_CONTROL_A     = 8'h0e;
  localparam logic [7:0] IDX_CONTROL_B     = 8'h0f;
  localparam logic [7:0] IDX_RESULT_UPPER  = 8'h10;
  localparam logic [7:0] IDX_RESULT_LOWER  = 8'h11;
  localparam logic [7:0] IDX_POWER_CTRL    = 8'h12;

  // ****************************************************************
  // Field layout and reset values
  // ****************************************************************
  localparam int          START_BIT        = 7;
  localparam int          MODE_LSB         = 5;
  localparam int          AIN_DIS_BIT      = 4;
  localparam int          LADDER_BIT       = 5;
  localparam int          CTIME_LSB        = 1;
  localparam int          DONE_BIT         = 5;
  localparam int          BUSY_BIT         = 4;
  localparam logic [7:0]  CONTROL_A_RESET  = 8'h10;
  localparam logic [5:0]  CONTROL_B_RESET  = 6'h00;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int          CLK_HZ           = 40_000_000;
  localparam int          NUM_BITS         = 10;
  localparam int          CNT_W            = 11;

  typedef enum logic [1:0] {
    MODE_OFF    = 2'b00,
    MODE_SINGLE = 2'b01,
    MODE_RSVD   = 2'b10,
    MODE_REPEAT = 2'b11
  } conv_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_CONV   = 2'b10,
    ST_STORE  = 2'b11
  } conv_state_t;

  typedef struct packed {
    logic       start;
    conv_mode_t mode;
    logic       ain_dis;
    logic [3:0] channel;
  } control_a_t;

  typedef struct packed {
    logic       ladder_on;
    logic       fix_one;
    logic [2:0] ctime;
    logic       fix_zero;
  } control_b_t;

  // Length in high-frequency clock cycles for each conversion time code.
  function automatic logic [CNT_W-1:0] conv_cycles(input logic [2:0] code);
    case (code)
      3'b000:  conv_cycles = 11'd39;
      3'b010:  conv_cycles = 11'd78;
      3'b011:  conv_cycles = 11'd156;
      3'b100:  conv_cycles = 11'd312;
      3'b101:  conv_cycles = 11'd624;
      3'b110:  conv_cycles = 11'd1248;
      default: conv_cycles = 11'd39;
    endcase
  endfunction : conv_cycles

endpackage : sar_adc_pkg

// ==== sar_approx.sv ====
// Purpose: Successive approximation register, one bit per step.
// Assumes: Comparator input already synchronised by the caller.
// Notes:   Trial code is always registered.

`timescale 1ns/1ps

module sar_approx
  import sar_adc_pkg::*;
#(
  parameter int WIDTH = NUM_BITS
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             resetn,
  // Control
  input  wire logic             begin_pulse,
  input  wire logic             step,
  input  wire logic             cmp_high,
  // Result
  output logic [WIDTH-1:0]      trial,
  output logic                  finished
);

  logic [WIDTH-1:0] code_reg, code_next;
  logic [WIDTH-1:0] mask_reg, mask_next;
  logic             fin_reg, fin_next;

  always_comb begin
    code_next = code_reg;
    mask_next = mask_reg;
    fin_next  = 1'b0;
    if (begin_pulse) begin
      mask_next = {1'b1, {(WIDTH-1){1'b0}}};
      code_next = {1'b1, {(WIDTH-1){1'b0}}};
    end else if (step && (mask_reg != '0)) begin
      // Keep the trial bit only if the held input is at or above the ladder.
      if (!cmp_high) begin
        code_next = code_reg & ~mask_reg;
      end
      mask_next = mask_reg >> 1;
      code_next = code_next | (mask_reg >> 1);
      fin_next  = (mask_reg[0] == 1'b1);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      code_reg <= '0;
      mask_reg <= '0;
      fin_reg  <= 1'b0;
    end else begin
      code_reg <= code_next;
      mask_reg <= mask_next;
      fin_reg  <= fin_next;
    end
  end

  assign trial    = code_reg;
  assign finished = fin_reg;

endmodule : sar_approx

// ==== sar_adc_control.sv ====
// Purpose: Register interface and sequencing of a 10-bit SAR converter.
// Assumes: 40 MHz CLK is the high-frequency clock; comparator and power
//          mode inputs are asynchronous.
// Notes:   Register set reached over APB with zero wait states.
//
// Decided for this implementation: the APB slave port.

`timescale 1ns/1ps

module sar_adc_control
  import sar_adc_pkg::*;
#(
  parameter int NBITS = NUM_BITS
) (
  // Clock and reset
  input  wire logic             CLK,
  input  wire logic             RESETN,
  // APB slave
  input  wire logic             PSEL,
  input  wire logic             PENABLE,
  input  wire logic             PWRITE,
  input  wire logic [11:0]      PADDR,
  input  wire logic [31:0]      PWDATA,
  output logic [31:0]           PRDATA,
  output logic                  PREADY,
  output logic                  PSLVERR,
  // Power mode
  input  wire logic             LOW_POWER_ENTRY,
  // Analog front end
  input  wire logic             CMP_HIGH,
  output logic                  SAMPLE_HOLD,
  output logic [NBITS-1:0]      LADDER_CODE,
  output logic                  LADDER_ENABLE,
  output logic [2:0]            INPUT_CHANNEL,
  output logic                  INPUT_ENABLE,
  // Event
  output logic                  CONV_DONE_IRQ
);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic cmp_s1_reg, cmp_s2_reg, lp_s1_reg, lp_s2_reg, lp_s3_reg;

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      cmp_s1_reg <= 1'b0;
      cmp_s2_reg <= 1'b0;
      lp_s1_reg  <= 1'b0;
      lp_s2_reg  <= 1'b0;
      lp_s3_reg  <= 1'b0;
    end else begin
      cmp_s1_reg <= CMP_HIGH;
      cmp_s2_reg <= cmp_s1_reg;
      lp_s1_reg  <= LOW_POWER_ENTRY;
      lp_s2_reg  <= lp_s1_reg;
      lp_s3_reg  <= lp_s2_reg;
    end
  end

  // Entry into a low-power mode is the rising edge of the synchronised level.
  logic lp_entry;
  assign lp_entry = lp_s2_reg & ~lp_s3_reg;

  // ****************************************************************
  // APB decode
  // ****************************************************************
  logic [9:0] word_idx;
  logic       wr_en, rd_en, hit_a, hit_b, hit_up, hit_lo, hit_pw, mapped;

  assign word_idx = PADDR[11:2];
  assign wr_en    = PSEL & PENABLE & PWRITE;
  assign rd_en    = PSEL & PENABLE & ~PWRITE;
  assign hit_a    = (word_idx == {2'b00, IDX_CONTROL_A});
  assign hit_b    = (word_idx == {2'b00, IDX_CONTROL_B});
  assign hit_up   = (word_idx == {2'b00, IDX_RESULT_UPPER});
  assign hit_lo   = (word_idx == {2'b00, IDX_RESULT_LOWER});
  assign hit_pw   = (word_idx == {2'b00, IDX_POWER_CTRL});
  assign mapped   = hit_a | hit_b | hit_up | hit_lo | hit_pw;

  // ****************************************************************
  // Control, status and sequencing state
  // ****************************************************************
  control_a_t        ctl_a_reg, ctl_a_next;
  control_b_t        ctl_b_reg, ctl_b_next;
  conv_state_t       state_reg, state_next;
  logic [CNT_W-1:0]  cnt_reg, cnt_next;
  logic [CNT_W-1:0]  len_reg, len_next;
  logic [NBITS-1:0]  result_reg, result_next;
  logic              done_reg, done_next;
  logic              irq_reg, irq_next;
  logic              sw_lp_reg, sw_lp_next;
  logic [31:0]       rdata_reg, rdata_next;
  logic              slverr_reg, slverr_next;
  logic              sar_begin, sar_step;
  logic [NBITS-1:0]  sar_trial;
  logic              sar_finished;
  logic              busy;
  logic              start_req;
  logic              stop_req;
  logic [CNT_W-1:0]  step_len;

  assign busy = (state_reg != ST_IDLE);
  // Spread the bit decisions evenly over the selected time.
  assign step_len = CNT_W'(len_reg / CNT_W'(NBITS + 1));

  sar_approx #(
    .WIDTH       (NBITS)
  ) u_sar (
    .clk         (CLK),
    .resetn      (RESETN),
    .begin_pulse (sar_begin),
    .step        (sar_step),
    .cmp_high    (cmp_s2_reg),
    .trial       (sar_trial),
    .finished    (sar_finished)
  );

  always_comb begin
    ctl_a_next  = ctl_a_reg;
    ctl_b_next  = ctl_b_reg;
    state_next  = state_reg;
    cnt_next    = cnt_reg;
    len_next    = len_reg;
    result_next = result_reg;
    done_next   = done_reg;
    irq_next    = 1'b0;
    sw_lp_next  = sw_lp_reg;
    rdata_next  = rdata_reg;
    slverr_next = 1'b0;
    sar_begin   = 1'b0;
    sar_step    = 1'b0;
    start_req   = 1'b0;
    stop_req    = 1'b0;

    // Register writes.
    if (wr_en && hit_a) begin
      ctl_a_next = control_a_t'(PWDATA[7:0]);
      if (PWDATA[START_BIT] && (PWDATA[MODE_LSB +: 2] != MODE_OFF)) begin
        start_req = 1'b1;
      end
      if (PWDATA[MODE_LSB +: 2] == MODE_OFF) begin
        stop_req = 1'b1;
      end
    end
    if (wr_en && hit_b) begin
      ctl_b_next = control_b_t'(PWDATA[5:0]);
    end
    if (wr_en && hit_pw) begin
      sw_lp_next = PWDATA[0];
    end

    // Read data are latched in the setup cycle so that they stand with PREADY.
    if (PSEL && !PENABLE) begin
      slverr_next = ~mapped;
      if (!PWRITE) begin
        rdata_next = 32'h0000_0000;
        if (hit_a) begin
          rdata_next[7:0] = ctl_a_reg;
        end
        if (hit_b) begin
          rdata_next[7:0] = {2'b00, ctl_b_reg};
        end
        if (hit_up) begin
          rdata_next[7:0] = result_reg[NBITS-1 -: 8];
        end
        if (hit_lo) begin
          rdata_next[7:0] = {result_reg[1:0], done_reg, busy, 4'h0};
        end
        if (hit_pw) begin
          rdata_next[0] = sw_lp_reg;
        end
      end
    end
    // Of status reads, only one that showed done clears it, so a completion that
    // lands between setup and access is not lost. A completion in the
    // access cycle itself wins, as the sequencer below sets done later.
    if (rd_en && hit_lo && rdata_reg[DONE_BIT]) begin
      done_next = 1'b0;
    end

    // Conversion sequencer.
    case (state_reg)
      ST_IDLE: begin
        if (start_req) begin
          state_next = ST_SAMPLE;
          len_next   = conv_cycles(ctl_b_reg.ctime);
          cnt_next   = '0;
          done_next  = 1'b0;
        end
      end
      ST_SAMPLE: begin
        ctl_a_next.start = 1'b0;
        cnt_next   = cnt_reg + 1'b1;
        if (cnt_reg + 1'b1 >= step_len) begin
          state_next = ST_CONV;
          sar_begin  = 1'b1;
          cnt_next   = '0;
        end
      end
      ST_CONV: begin
        cnt_next = cnt_reg + 1'b1;
        if (cnt_reg + 1'b1 >= step_len) begin
          sar_step = 1'b1;
          cnt_next = '0;
        end
        if (sar_finished) begin
          state_next = ST_STORE;
        end
      end
      ST_STORE: begin
        result_next = sar_trial;
        done_next   = 1'b1;
        irq_next    = 1'b1;
        cnt_next    = '0;
        if (ctl_a_reg.mode == MODE_REPEAT) begin
          state_next = ST_SAMPLE;
          len_next   = conv_cycles(ctl_b_reg.ctime);
        end else begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase

    // Disabling stops at once and drops the partial value.
    if (stop_req && busy) begin
      state_next  = ST_IDLE;
      result_next = result_reg;
      done_next   = done_reg;
      irq_next    = 1'b0;
    end

    // Low-power entry wins over everything else.
    if (lp_entry || (wr_en && hit_pw && PWDATA[0] && !sw_lp_reg)) begin
      ctl_a_next  = control_a_t'(CONTROL_A_RESET);
      ctl_b_next  = control_b_t'(CONTROL_B_RESET);
      state_next  = ST_IDLE;
      result_next = '0;
      done_next   = 1'b0;
      irq_next    = 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      ctl_a_reg  <= control_a_t'(CONTROL_A_RESET);
      ctl_b_reg  <= control_b_t'(CONTROL_B_RESET);
      state_reg  <= ST_IDLE;
      cnt_reg    <= '0;
      len_reg    <= '0;
      result_reg <= '0;
      done_reg   <= 1'b0;
      irq_reg    <= 1'b0;
      sw_lp_reg  <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      slverr_reg <= 1'b0;
    end else begin
      ctl_a_reg  <= ctl_a_next;
      ctl_b_reg  <= ctl_b_next;
      state_reg  <= state_next;
      cnt_reg    <= cnt_next;
      len_reg    <= len_next;
      result_reg <= result_next;
      done_reg   <= done_next;
      irq_reg    <= irq_next;
      sw_lp_reg  <= sw_lp_next;
      rdata_reg  <= rdata_next;
      slverr_reg <= slverr_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  logic              sh_reg, ladder_reg, in_en_reg;
  logic [2:0]        chan_reg;
  logic              ready_reg;

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      sh_reg       <= 1'b0;
      ladder_reg   <= 1'b0;
      in_en_reg    <= 1'b0;
      chan_reg     <= 3'h0;
      ready_reg    <= 1'b0;
    end else begin
      sh_reg       <= (state_next == ST_SAMPLE);
      ladder_reg   <= ctl_b_next.ladder_on | (state_next != ST_IDLE);
      in_en_reg    <= ~ctl_a_next.ain_dis;
      // Reserved channel codes leave the mux on the low eight inputs.
      chan_reg     <= ctl_a_next.channel[2:0];
      ready_reg    <= PSEL & ~PENABLE;
    end
  end

  assign SAMPLE_HOLD   = sh_reg;
  assign LADDER_ENABLE = ladder_reg;
  assign INPUT_ENABLE  = in_en_reg;
  assign INPUT_CHANNEL = chan_reg;
  // The trial register drives the ladder directly: one more stage would
  // leave the synchronised comparator a cycle late at the shortest step.
  assign LADDER_CODE   = sar_trial;
  assign CONV_DONE_IRQ = irq_reg;
  assign PRDATA        = rdata_reg;
  assign PSLVERR       = slverr_reg;
  assign PREADY        = ready_reg;

endmodule : sar_adc_control

// ==== sar_frontend_model.sv ====
// Purpose: Sample-and-hold and comparator seen by the converter control.
// Assumes: Each channel carries a fixed level chosen by channel number.
// Notes:   The comparator tests held >= ladder_code, so a tie reads high.
`timescale 1ns/1ps
module sar_frontend_model (
  // Converter side
  input  wire logic       clk,
  input  wire logic       sample_hold,
  input  wire logic [9:0] ladder_code,
  input  wire logic [2:0] channel,
  input  wire logic       input_enable,
  output logic            cmp_high
);
  logic [9:0] held = 10'h000;
  always @(posedge clk) begin
    if (sample_hold) begin
      held <= input_enable ? 10'(channel * 131 + 53) : 10'h000;
    end
  end
  assign cmp_high = (held >= ladder_code);
endmodule : sar_frontend_model

// ==== sar_adc_control_asserts.sv ====
// Purpose: Port-level checks on the converter control block.
// Assumes: One clock domain; RESETN asynchronous, active low.
// Notes:   Attached to every instance by the bind at the foot.
`timescale 1ns/1ps
module sar_adc_control_asserts
  import sar_adc_pkg::*;
#(
  parameter int NBITS = NUM_BITS
) (
  // Clock, reset and register bus
  input wire logic             CLK,
  input wire logic             RESETN,
  input wire logic             PSEL,
  input wire logic             PENABLE,
  input wire logic             PWRITE,
  input wire logic [11:0]      PADDR,
  input wire logic [31:0]      PWDATA,
  input wire logic             PREADY,
  // Power and analog side
  input wire logic             LOW_POWER_ENTRY,
  input wire logic             SAMPLE_HOLD,
  input wire logic [NBITS-1:0] LADDER_CODE,
  input wire logic             LADDER_ENABLE,
  input wire logic [2:0]       INPUT_CHANNEL,
  input wire logic             INPUT_ENABLE,
  input wire logic             CONV_DONE_IRQ
);
  // ****
  // Properties
  // ****
  default clocking dc @(posedge CLK); endclocking
  default disable iff (!RESETN);
  logic wr_a;
  assign wr_a = PSEL && PENABLE && PWRITE && PREADY && PADDR == {2'h0, IDX_CONTROL_A, 2'h0};

  a_irq_one_pulse: assert property (CONV_DONE_IRQ |=> !CONV_DONE_IRQ)
    else $error("done event longer than one cycle");
  a_channel_routed: assert property (wr_a |=> ##1 INPUT_CHANNEL == $past(PWDATA[2:0], 2))
    else $error("channel output does not follow write");
  a_input_gate: assert property (wr_a |=> ##1 INPUT_ENABLE == !$past(PWDATA[4], 2))
    else $error("input enable does not follow disable bit");
  a_power_clears: assert property ($rose(LOW_POWER_ENTRY) |-> ##[3:8] !INPUT_ENABLE)
    else $error("low power entry left control set");
  a_start_samples: assert property (
    wr_a && PWDATA[7] && PWDATA[6:5] == 2'h1 && !LADDER_ENABLE |-> ##[1:3] SAMPLE_HOLD)
    else $error("start did not begin sampling");
  a_no_early_done: assert property ($rose(SAMPLE_HOLD) |=> ##1 !CONV_DONE_IRQ [*6])
    else $error("conversion ended too soon");
  a_ladder_in_conv: assert property (SAMPLE_HOLD |-> LADDER_ENABLE)
    else $error("ladder off during conversion");
  a_abort_quiet: assert property (
    wr_a && PWDATA[6:5] == 2'h0 |=> ##2 !CONV_DONE_IRQ [*8])
    else $error("completion after disable");
endmodule : sar_adc_control_asserts

bind sar_adc_control sar_adc_control_asserts #(.NBITS(NBITS)) i_sar_adc_control_asserts (
  .CLK(CLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .LOW_POWER_ENTRY(LOW_POWER_ENTRY),
  .SAMPLE_HOLD(SAMPLE_HOLD), .LADDER_CODE(LADDER_CODE), .LADDER_ENABLE(LADDER_ENABLE),
  .INPUT_CHANNEL(INPUT_CHANNEL), .INPUT_ENABLE(INPUT_ENABLE), .CONV_DONE_IRQ(CONV_DONE_IRQ)
);

// ==== sar_adc_control_bench.sv ====
// Purpose: Self-checking bench for the converter control block.
// Assumes: Zero-wait APB slave; comparator from sar_frontend_model.
// Notes:   Lengths get a 15 cycle margin, as the sequencer rounds its steps.
`timescale 1ns/1ps
module sar_adc_control_bench;
  import sar_adc_pkg::*;
  localparam logic [11:0] A_CA  = {2'h0, IDX_CONTROL_A, 2'h0};
  localparam logic [11:0] A_CB  = {2'h0, IDX_CONTROL_B, 2'h0};
  localparam logic [11:0] A_RU  = {2'h0, IDX_RESULT_UPPER, 2'h0};
  localparam logic [11:0] A_RL  = {2'h0, IDX_RESULT_LOWER, 2'h0};
  logic        CLK = 1'h0;
  logic        RESETN = 1'h0;
  logic        PSEL = 1'h0;
  logic        PENABLE = 1'h0;
  logic        PWRITE = 1'h0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0;
  logic        LOW_POWER_ENTRY = 1'h0;
  logic [31:0] PRDATA;
  logic        PREADY;
  logic        PSLVERR;
  logic        CMP_HIGH;
  logic        SAMPLE_HOLD;
  logic [9:0]  LADDER_CODE;
  logic        LADDER_ENABLE;
  logic [2:0]  INPUT_CHANNEL;
  logic        INPUT_ENABLE;
  logic        CONV_DONE_IRQ;
  logic [31:0] rv;
  logic        rerr;
  logic [9:0]  last;
  int          n_errors = 0;
  int          num_checks = 0;
  int          tick = 0;
  int          t0;
  int          nirq;

  always #12.5 CLK = ~CLK;
  always @(posedge CLK) tick <= tick + 1;

  sar_adc_control i_sar_adc_control (
    .CLK(CLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .LOW_POWER_ENTRY(LOW_POWER_ENTRY), .CMP_HIGH(CMP_HIGH), .SAMPLE_HOLD(SAMPLE_HOLD),
    .LADDER_CODE(LADDER_CODE), .LADDER_ENABLE(LADDER_ENABLE),
    .INPUT_CHANNEL(INPUT_CHANNEL), .INPUT_ENABLE(INPUT_ENABLE), .CONV_DONE_IRQ(CONV_DONE_IRQ)
  );
  sar_frontend_model i_sar_frontend_model (
    .clk(CLK), .sample_hold(SAMPLE_HOLD), .ladder_code(LADDER_CODE),
    .channel(INPUT_CHANNEL), .input_enable(INPUT_ENABLE), .cmp_high(CMP_HIGH)
  );

  task automatic print_verdict;
    if (n_errors == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t ns: seen %h, expected %h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [9:0] lvl(input logic [2:0] ch);
    lvl = 10'(ch * 131 + 53);
  endfunction : lvl

  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge CLK);
    PSEL <= 1'h1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= {24'h0, d};
    @(posedge CLK);
    PENABLE <= 1'h1;
    do begin
      @(posedge CLK);
    end while (PREADY !== 1'h1);
    rv = PRDATA;
    rerr = PSLVERR;
    PSEL <= 1'h0;
    PENABLE <= 1'h0;
  endtask : apb

  // Single conversion on channel i with the i-th time code.
  task automatic run(input int i);
    logic [9:0] exp;
    exp = lvl(3'(i));
    apb(1'h1, A_CB, {4'h1, ((i == 0) ? 3'h0 : 3'(i + 1)), 1'h0});
    apb(1'h1, A_CA, {5'h14, 3'(i)});
    t0 = tick;
    apb(1'h0, A_CA, 8'h0);
    check(rv, {24'h0, 5'h04, 3'(i)});
    check(32'(INPUT_CHANNEL), 32'(i));
    apb(1'h0, A_RL, 8'h0);
    check(rv & 32'h30, 32'h10);
    if (i > 0) begin
      apb(1'h0, A_RU, 8'h0);
      check(rv, {24'h0, last[9:2]});
    end
    while (CONV_DONE_IRQ !== 1'h1 && tick - t0 < 3000) @(posedge CLK);
    check(32'(LADDER_CODE), 32'(exp));
    check(32'(tick - t0 >= (39 << i) - 15 && tick - t0 <= (39 << i) + 15), 32'h1);
    apb(1'h0, A_RU, 8'h0);
    check(rv, {24'h0, exp[9:2]});
    // Odd runs leave done set so the next start has to clear it.
    if (i % 2 == 0) begin
      apb(1'h0, A_RL, 8'h0);
      check(rv, {24'h0, exp[1:0], 6'h20});
      apb(1'h0, A_RL, 8'h0);
      check(rv, {24'h0, exp[1:0], 6'h00});
    end
    last = exp;
  endtask : run

  // ****
  // Stimulus
  // ****
  initial begin
    repeat (3) @(posedge CLK);
    RESETN <= 1'h1;
    apb(1'h0, A_CA, 8'h0);
    check(rv, 32'h10);
    apb(1'h0, A_CB, 8'h0);
    check(rv & 32'h3f, 32'h0);
    check(32'({INPUT_ENABLE, LADDER_ENABLE}), 32'h0);
    apb(1'h0, 12'h04c, 8'h0);
    check(32'(rerr), 32'h1);
    for (int i = 0; i < 6; i++) begin
      run(i);
    end
    apb(1'h1, A_CB, 8'h10);
    apb(1'h1, A_CA, 8'he5);
    t0 = tick;
    nirq = 0;
    while (tick - t0 < 200) begin
      @(posedge CLK);
      if (CONV_DONE_IRQ === 1'h1) nirq++;
    end
    check(32'(nirq >= 4), 32'h1);
    apb(1'h1, A_CA, 8'h05);
    nirq = 0;
    repeat (100) begin
      @(posedge CLK);
      if (CONV_DONE_IRQ === 1'h1) nirq++;
    end
    check(32'(nirq), 32'h0);
    last = lvl(3'h5);
    apb(1'h0, A_RL, 8'h0);
    check(rv & 32'hd0, {24'h0, last[1:0], 6'h00});
    apb(1'h0, A_RU, 8'h0);
    check(rv, {24'h0, last[9:2]});
    apb(1'h1, A_CB, 8'h30);
    repeat (2) @(posedge CLK);
    check(32'(LADDER_ENABLE), 32'h1);
    apb(1'h1, A_CB, 8'h3c);
    apb(1'h1, A_CA, 8'ha3);
    LOW_POWER_ENTRY <= 1'h1;
    repeat (8) @(posedge CLK);
    LOW_POWER_ENTRY <= 1'h0;
    apb(1'h0, A_CA, 8'h0);
    check(rv, 32'h10);
    apb(1'h0, A_CB, 8'h0);
    check(rv & 32'h3f, 32'h0);
    apb(1'h0, A_RL, 8'h0);
    check(rv & 32'h30, 32'h0);
    check(32'({INPUT_ENABLE, LADDER_ENABLE}), 32'h0);
    print_verdict();
  end

  initial begin
    repeat (20000) @(posedge CLK);
    n_errors++;
    print_verdict();
  end
endmodule : sar_adc_control_bench
